// [include/ebu_params.svh]
// constants for the external bus unit window controller
//
// Summary of operation
// R1 - single-chip mode issues no external cycles
// R2 - four modes: mux/demux, 8/16-bit data
// R3 - demux: address on demux lines, data shared
// R4 - mux: address then data on shared lines
// R5 - cycle, tristate, strobe, rw delay programmable
// R6 - four windows, each range plus settings
// R7 - window four beats three, two beats one
// R8 - outside all windows use default settings
// R9 - five active-low window selects
// R10 - arbitration only after arbitration_on set
// R11 - arbitration pins owned by unit when enabled
// R12 - master after reset, direction bit selects slave
// R13 - address space limit 1M, 256K, 64K
// R14 - eight, four, two or no segment lines
// R15 - selects change one cycle after strobe
// R16 - timing choice: selects change at strobe edge
// R17 - ready polarity per window settings
// R18 - ready ends cycle, cycle extended until seen
// R19 - master grants bus after current cycle
`ifndef EBU_PARAMS_SVH
`define EBU_PARAMS_SVH
`define EBU_NWIN      4
`define EBU_ADDR_W    24
`define EBU_RANGE_W   12
`define EBU_SIZE_W    4
`define EBU_MODE_OFF  3'h0
`define EBU_MODE_D16  3'h1
`define EBU_MODE_M8   3'h2
`define EBU_MODE_M16  3'h3
`define EBU_MODE_D8   3'h4
`define EBU_SPC_16M   2'h0
`define EBU_SPC_1M    2'h1
`define EBU_SPC_256K  2'h2
`define EBU_SPC_64K   2'h3
`define EBU_SEG_16M   8'hff
`define EBU_SEG_1M    8'h0f
`define EBU_SEG_256K  8'h03
`define EBU_SEG_64K   8'h00
`define EBU_CNT_W     4
`define EBU_CNT_ONE   4'h1
`define EBU_CNT_ZERO  4'h0
`endif

// [include/ebu_pkg.sv]
// types for the external bus unit window controller
package ebu_pkg;
  // one bus settings word
  typedef struct packed {
    logic       enable;
    logic [2:0] mode;
    logic [3:0] cycle_wait;
    logic [3:0] tristate_wait;
    logic       long_strobe;
    logic       rw_delay;
    logic       ready_en;
    logic       wait_done_polarity;
  } bus_settings_t;
  // one window range select: base of 12 upper bits plus size code
  typedef struct packed {
    logic [11:0] base;
    logic [3:0]  size;
  } window_range_t;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_RWDLY = 3'b011,
    ST_DATA  = 3'b010,
    ST_WAITR = 3'b110,
    ST_TRIS  = 3'b111,
    ST_HOLD  = 3'b101
  } bus_state_t;
endpackage

// [hdl/ebu_window_ctrl.sv]
// external bus unit with address windows, selects, ready and arbitration
`timescale 1ns/100ps
`include "ebu_params.svh"
module ebu_window_ctrl (
  input  wire logic                   i_clk,
  input  wire logic                   i_rst,
  input  wire ebu_pkg::bus_settings_t i_default_bus_settings,
  input  wire ebu_pkg::bus_settings_t i_window_one_settings,
  input  wire ebu_pkg::bus_settings_t i_window_two_settings,
  input  wire ebu_pkg::bus_settings_t i_window_three_settings,
  input  wire ebu_pkg::bus_settings_t i_window_four_settings,
  input  wire ebu_pkg::window_range_t i_range_one,
  input  wire ebu_pkg::window_range_t i_range_two,
  input  wire ebu_pkg::window_range_t i_range_three,
  input  wire ebu_pkg::window_range_t i_range_four,
  input  wire logic [1:0]             i_space_limit,
  input  wire logic                   i_select_timing_choice,
  input  wire logic                   i_arbitration_on,
  input  wire logic                   i_grant_pin_direction,
  input  wire logic                   i_req,
  input  wire logic                   i_req_write,
  input  wire logic [23:0]            i_req_addr,
  input  wire logic [15:0]            i_req_wdata,
  input  wire logic                   i_ready,
  input  wire logic [15:0]            i_shared_ad_lines,
  input  wire logic                   i_bus_grab_req_n,
  input  wire logic                   i_grant_acknowledge_n,
  output logic                        o_req_done,
  output logic [15:0]                 o_req_rdata,
  output logic [15:0]                 o_shared_ad_lines,
  output logic                        o_shared_ad_oe_n,
  output logic [15:0]                 o_demux_addr_lines,
  output logic [7:0]                  o_segment_addr,
  output logic                        o_addr_strobe,
  output logic                        o_rd_n,
  output logic                        o_wr_n,
  output logic [4:0]                  o_window_select_n,
  output logic                        o_bus_want_out_n,
  output logic                        o_grant_acknowledge_n,
  output logic                        o_grant_ack_oe_n,
  output logic                        o_bus_floated
);
  // ****************************************
  // window decode
  // ****************************************
  // size code n: window spans 4K << n bytes; low n base bits masked off
  function automatic logic win_hit(input ebu_pkg::window_range_t r, input logic [23:0] a);
    logic [11:0] mask;
    mask = 12'hfff << r.size;
    win_hit = ((a[23:12] & mask) == (r.base & mask));
  endfunction

  wire       hit1 = win_hit(i_range_one, i_req_addr) & i_window_one_settings.enable;
  wire       hit2 = win_hit(i_range_two, i_req_addr) & i_window_two_settings.enable;
  wire       hit3 = win_hit(i_range_three, i_req_addr) & i_window_three_settings.enable;
  wire       hit4 = win_hit(i_range_four, i_req_addr) & i_window_four_settings.enable;
  // four over three, two over one; pair 3/4 taken over pair 1/2
  wire [2:0] win_sel = hit4 ? 3'h4 : hit3 ? 3'h3 : hit2 ? 3'h2 : hit1 ? 3'h1 : 3'h0; // R7 R8
  ebu_pkg::bus_settings_t cfg_sel;
  assign cfg_sel = (win_sel == 3'h4) ? i_window_four_settings : // R6
                   (win_sel == 3'h3) ? i_window_three_settings :
                   (win_sel == 3'h2) ? i_window_two_settings :
                   (win_sel == 3'h1) ? i_window_one_settings : i_default_bus_settings; // R8
  wire [7:0] seg_mask = (i_space_limit == `EBU_SPC_1M)   ? `EBU_SEG_1M :   // R13 R14
                        (i_space_limit == `EBU_SPC_256K) ? `EBU_SEG_256K :
                        (i_space_limit == `EBU_SPC_64K)  ? `EBU_SEG_64K : `EBU_SEG_16M;

  // ****************************************
  // arbitration
  // ****************************************
  wire grab = i_arbitration_on & ~i_grant_pin_direction & ~i_bus_grab_req_n; // R10 R19
  // slave only drives the bus while the other master acknowledges
  wire slave_has_bus = ~i_grant_pin_direction | ~i_arbitration_on | ~i_grant_acknowledge_n;

  // ****************************************
  // bus cycle sequencer
  // ****************************************
  ebu_pkg::bus_state_t    state_ff, nxt_state;
  ebu_pkg::bus_settings_t cfg_ff;
  logic [`EBU_CNT_W-1:0]  cnt_ff;
  logic [2:0]             win_ff;
  logic                   wr_ff;
  logic [23:0]            addr_ff;
  logic [15:0]            wdata_ff;
  logic                   strobe_rose_ff;

  wire cfg_mux   = (cfg_ff.mode == `EBU_MODE_M8) | (cfg_ff.mode == `EBU_MODE_M16); // R2
  wire cfg_byte  = (cfg_ff.mode == `EBU_MODE_M8) | (cfg_ff.mode == `EBU_MODE_D8); // R2 R3
  wire rdy_seen  = ~cfg_ff.ready_en | (i_ready == cfg_ff.wait_done_polarity);   // R17 R18
  wire cnt_zero  = (cnt_ff == `EBU_CNT_ZERO);
  wire start_ok  = i_req & ~grab & slave_has_bus & (cfg_sel.mode != `EBU_MODE_OFF); // R1
  wire req_nop   = i_req & (cfg_sel.mode == `EBU_MODE_OFF);                         // R1

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ebu_pkg::ST_IDLE:  if (grab) nxt_state = ebu_pkg::ST_HOLD;
                         else if (start_ok) nxt_state = ebu_pkg::ST_ADDR;
      ebu_pkg::ST_ADDR:  if (cnt_zero) nxt_state = cfg_ff.rw_delay ? ebu_pkg::ST_RWDLY
                                                                    : ebu_pkg::ST_DATA;
      ebu_pkg::ST_RWDLY: nxt_state = ebu_pkg::ST_DATA;
      ebu_pkg::ST_DATA:  if (cnt_zero) nxt_state = ebu_pkg::ST_WAITR;
      ebu_pkg::ST_WAITR: if (rdy_seen) nxt_state = ebu_pkg::ST_TRIS; // R18
      ebu_pkg::ST_TRIS:  if (cnt_zero) nxt_state = ebu_pkg::ST_IDLE;
      ebu_pkg::ST_HOLD:  if (!grab) nxt_state = ebu_pkg::ST_IDLE;    // R19
      default:           nxt_state = ebu_pkg::ST_IDLE;
    endcase
  end

  // wait counts per phase
  wire [`EBU_CNT_W-1:0] strobe_len = cfg_sel.long_strobe ? `EBU_CNT_ONE : `EBU_CNT_ZERO; // R5
  wire [`EBU_CNT_W-1:0] nxt_cnt =
      (state_ff == ebu_pkg::ST_IDLE)                 ? strobe_len :
      (nxt_state != state_ff && nxt_state == ebu_pkg::ST_DATA) ? cfg_ff.cycle_wait :     // R5
      (nxt_state != state_ff && nxt_state == ebu_pkg::ST_TRIS) ? cfg_ff.tristate_wait :  // R5
      cnt_zero ? cnt_ff : cnt_ff - `EBU_CNT_ONE;
  wire enter_cycle = (state_ff == ebu_pkg::ST_IDLE) & start_ok & ~grab;
  wire in_cycle    = (state_ff != ebu_pkg::ST_IDLE) & (state_ff != ebu_pkg::ST_HOLD);
  wire in_data     = (state_ff == ebu_pkg::ST_DATA) | (state_ff == ebu_pkg::ST_WAITR);
  wire finish      = (state_ff == ebu_pkg::ST_WAITR) & rdy_seen;
  wire strobe_fall = (state_ff == ebu_pkg::ST_ADDR) & cnt_zero;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_ff <= ebu_pkg::ST_IDLE;
      cnt_ff   <= `EBU_CNT_ZERO;
      cfg_ff   <= '0;
      win_ff   <= 3'h0;
      wr_ff    <= 1'b0;
      addr_ff  <= 24'h000000;
      wdata_ff <= 16'h0000;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      if (enter_cycle) begin
        cfg_ff   <= cfg_sel;
        win_ff   <= win_sel;
        wr_ff    <= i_req_write;
        addr_ff  <= i_req_addr;
        wdata_ff <= i_req_wdata;
      end
    end
  end

  // ****************************************
  // pin drivers, all registered
  // ****************************************
  wire        nxt_strobe  = enter_cycle | ((state_ff == ebu_pkg::ST_ADDR) & ~cnt_zero);
  wire        nxt_in_data = (nxt_state == ebu_pkg::ST_DATA) | (nxt_state == ebu_pkg::ST_WAITR);
  wire        nxt_in_bus  = (nxt_state != ebu_pkg::ST_IDLE) & (nxt_state != ebu_pkg::ST_HOLD);
  wire [23:0] nxt_addr    = enter_cycle ? i_req_addr : addr_ff;
  wire        nxt_mux     = enter_cycle ? ((cfg_sel.mode == `EBU_MODE_M8) |
                                           (cfg_sel.mode == `EBU_MODE_M16)) : cfg_mux;
  wire [15:0] nxt_wdata   = cfg_byte ? {8'h00, wdata_ff[7:0]} : wdata_ff;
  wire        nxt_drive_ad = nxt_in_bus & ((nxt_mux & (nxt_state == ebu_pkg::ST_ADDR)) |
                                           (wr_ff & nxt_in_data));
  wire [15:0] nxt_ad = (nxt_mux & ~nxt_in_data) ? nxt_addr[15:0] : nxt_wdata; // R3 R4
  // early mode: select follows the strobe edge; late mode waits one more edge
  wire        cs_go  = i_select_timing_choice ? enter_cycle : strobe_rose_ff; // R15 R16
  wire [4:0]  cs_vec = 5'h01 << win_ff;
  wire [4:0]  cs_now = 5'h01 << win_sel;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_req_done            <= 1'b0;
      o_req_rdata           <= 16'h0000;
      o_shared_ad_lines     <= 16'h0000;
      o_shared_ad_oe_n      <= 1'b1;
      o_demux_addr_lines    <= 16'h0000;
      o_segment_addr        <= 8'h00;
      o_addr_strobe         <= 1'b0;
      o_rd_n                <= 1'b1;
      o_wr_n                <= 1'b1;
      o_window_select_n     <= 5'h1f;
      strobe_rose_ff        <= 1'b0;
      o_bus_want_out_n      <= 1'b1;
      o_grant_acknowledge_n <= 1'b1;
      o_grant_ack_oe_n      <= 1'b0;
      o_bus_floated         <= 1'b0;
    end else begin
      o_req_done         <= finish | req_nop & (state_ff == ebu_pkg::ST_IDLE);  // R1
      if (finish && !wr_ff)
        o_req_rdata      <= cfg_byte | (cfg_ff.mode == `EBU_MODE_OFF) ? // R3
                            {8'h00, i_shared_ad_lines[7:0]} : i_shared_ad_lines;
      o_shared_ad_lines  <= nxt_ad;                                      // R3 R4
      o_shared_ad_oe_n   <= ~nxt_drive_ad;
      o_demux_addr_lines <= nxt_addr[15:0];                              // R3
      o_segment_addr     <= nxt_addr[23:16] & seg_mask;                  // R14
      o_addr_strobe      <= nxt_strobe;
      o_rd_n             <= ~(nxt_in_data & ~wr_ff & ~enter_cycle);
      o_wr_n             <= ~(nxt_in_data & wr_ff);
      strobe_rose_ff     <= enter_cycle;
      if (cs_go)
        o_window_select_n <= ~(i_select_timing_choice ? cs_now : cs_vec); // R9 R16
      else if (finish)
        o_window_select_n <= 5'h1f;
      // without arbitration the want pin stays high; the grant pin stays enabled as an output, driven high
      o_bus_want_out_n   <= ~(i_arbitration_on & i_grant_pin_direction & i_req &
                              i_grant_acknowledge_n);                    // R11
      o_grant_acknowledge_n <= ~(nxt_state == ebu_pkg::ST_HOLD);         // R19
      o_grant_ack_oe_n   <= i_arbitration_on & i_grant_pin_direction;    // R12
      o_bus_floated      <= (nxt_state == ebu_pkg::ST_HOLD);
    end
  end

  // ****************************************
  // checks
  // ****************************************
  chk_single_chip_quiet: assert property (@(posedge i_clk) disable iff (i_rst) // R1
    (state_ff == ebu_pkg::ST_IDLE && req_nop) |=> o_addr_strobe == 1'b0)
    else $error("strobe raised in single-chip mode");
  chk_hold_floats_bus: assert property (@(posedge i_clk) disable iff (i_rst) // R19
    o_bus_floated |-> o_shared_ad_oe_n && o_rd_n && o_wr_n && !o_grant_acknowledge_n)
    else $error("bus not floated during grant");
  chk_grab_granted: assert property (@(posedge i_clk) disable iff (i_rst) // R10 R19
    (grab && state_ff == ebu_pkg::ST_IDLE) |=> !o_grant_acknowledge_n)
    else $error("grab not acknowledged");
  chk_no_grant_off: assert property (@(posedge i_clk) disable iff (i_rst) // R10
    !i_arbitration_on |=> o_grant_acknowledge_n)
    else $error("grant without arbitration enabled");
  chk_ready_extends: assert property (@(posedge i_clk) disable iff (i_rst) // R18
    (state_ff == ebu_pkg::ST_WAITR && !rdy_seen) |=> state_ff == ebu_pkg::ST_WAITR)
    else $error("cycle ended without ready");
  chk_priority_four: assert property (@(posedge i_clk) disable iff (i_rst) // R7
    (hit4 && hit3) |-> win_sel == 3'h4)
    else $error("window four did not win");
  chk_seg_64k: assert property (@(posedge i_clk) disable iff (i_rst) // R14
    $past(i_space_limit) == `EBU_SPC_64K |-> o_segment_addr == 8'h00)
    else $error("segment lines driven in 64K space");
  chk_master_dir: assert property (@(posedge i_clk) disable iff (i_rst) // R12
    !$past(i_grant_pin_direction) |-> !o_grant_ack_oe_n)
    else $error("grant pin not output in master role");
  chk_late_select: assert property (@(posedge i_clk) disable iff (i_rst) // R15
    (enter_cycle && !i_select_timing_choice) |=> o_window_select_n == 5'h1f)
    else $error("select changed too early");
  chk_late_select_on: assert property (@(posedge i_clk) disable iff (i_rst) // R15
    (enter_cycle && !i_select_timing_choice) |=> ##1 o_window_select_n != 5'h1f)
    else $error("late select missing");
  chk_early_select: assert property (@(posedge i_clk) disable iff (i_rst) // R16
    (enter_cycle && i_select_timing_choice) |=> o_window_select_n != 5'h1f)
    else $error("early select missing");
  chk_one_select: assert property (@(posedge i_clk) disable iff (i_rst) // R9
    $countones(~o_window_select_n) <= 1)
    else $error("more than one select low");
  chk_select_cleared: assert property (@(posedge i_clk) disable iff (i_rst) // R9
    o_req_done |-> o_window_select_n == 5'h1f)
    else $error("select held past done");
  chk_ready_ends: assert property (@(posedge i_clk) disable iff (i_rst) // R18
    (state_ff == ebu_pkg::ST_WAITR && rdy_seen) |=> o_req_done)
    else $error("ready did not end cycle");
  chk_long_strobe: assert property (@(posedge i_clk) disable iff (i_rst) // R5
    (enter_cycle && cfg_sel.long_strobe) |=> o_addr_strobe ##1 o_addr_strobe)
    else $error("long strobe too short");
  chk_strobe_drops: assert property (@(posedge i_clk) disable iff (i_rst) // R5
    strobe_fall |=> !o_addr_strobe)
    else $error("strobe held too long");
  chk_strobe_in_cycle: assert property (@(posedge i_clk) disable iff (i_rst) // R5
    o_addr_strobe |-> in_cycle)
    else $error("strobe outside a cycle");
  chk_rw_delay: assert property (@(posedge i_clk) disable iff (i_rst) // R5
    (strobe_fall && cfg_ff.rw_delay) |=> o_rd_n && o_wr_n)
    else $error("strobe not delayed");
  chk_tristate_quiet: assert property (@(posedge i_clk) disable iff (i_rst) // R5
    (state_ff == ebu_pkg::ST_TRIS) |-> o_shared_ad_oe_n && o_rd_n && o_wr_n)
    else $error("bus driven in tristate time");
  chk_mux_addr: assert property (@(posedge i_clk) disable iff (i_rst) // R4
    (enter_cycle && nxt_mux) |=> !o_shared_ad_oe_n &&
    o_shared_ad_lines == $past(i_req_addr[15:0]))
    else $error("mux address phase wrong");
  chk_demux_addr: assert property (@(posedge i_clk) disable iff (i_rst) // R3
    enter_cycle |=> o_demux_addr_lines == $past(i_req_addr[15:0]))
    else $error("demux address wrong");
  chk_byte_data: assert property (@(posedge i_clk) disable iff (i_rst) // R3
    (!o_wr_n && cfg_byte) |-> o_shared_ad_lines[15:8] == 8'h00)
    else $error("upper byte driven in byte mode");
  chk_rw_in_data: assert property (@(posedge i_clk) disable iff (i_rst) // R4
    (!o_rd_n || !o_wr_n) |-> in_data)
    else $error("strobe outside data phase");
  chk_nop_done: assert property (@(posedge i_clk) disable iff (i_rst) // R1
    (state_ff == ebu_pkg::ST_IDLE && req_nop) |=> o_req_done && o_window_select_n == 5'h1f)
    else $error("single-chip request mishandled");
  chk_want_off: assert property (@(posedge i_clk) disable iff (i_rst) // R10
    !$past(i_arbitration_on) |-> o_bus_want_out_n)
    else $error("bus wanted without arbitration");
  chk_slave_waits: assert property (@(posedge i_clk) disable iff (i_rst) // R11 R12
    (state_ff == ebu_pkg::ST_IDLE && !slave_has_bus) |=> !o_addr_strobe)
    else $error("slave started without the bus");
  chk_slave_pin_in: assert property (@(posedge i_clk) disable iff (i_rst) // R12
    $past(i_arbitration_on && i_grant_pin_direction) |-> o_grant_ack_oe_n)
    else $error("grant pin driven in slave role");
  chk_grant_released: assert property (@(posedge i_clk) disable iff (i_rst) // R19
    (state_ff == ebu_pkg::ST_HOLD && !grab) |=> o_grant_acknowledge_n)
    else $error("grant kept after request left");
  chk_floated_quiet: assert property (@(posedge i_clk) disable iff (i_rst) // R19
    o_bus_floated |-> !o_addr_strobe && o_window_select_n == 5'h1f)
    else $error("bus active during grant");
  chk_seg_1m: assert property (@(posedge i_clk) disable iff (i_rst) // R14
    $past(i_space_limit) == `EBU_SPC_1M |-> o_segment_addr[7:4] == 4'h0)
    else $error("segment lines above 1M");
  chk_seg_256k: assert property (@(posedge i_clk) disable iff (i_rst) // R14
    $past(i_space_limit) == `EBU_SPC_256K |-> o_segment_addr[7:2] == 6'h00)
    else $error("segment lines above 256K");
  chk_seg_full: assert property (@(posedge i_clk) disable iff (i_rst) // R13 R14
    $past(i_space_limit) == `EBU_SPC_16M |-> o_segment_addr == $past(nxt_addr[23:16]))
    else $error("segment lines wrong in 16M space");
endmodule

// [dv/ebu_mem_model.sv]
// external memory model answering the bus unit with data and a ready line
`timescale 1ns/100ps
module ebu_mem_model #(
  parameter logic [15:0] RD_WORD = 16'hc3a5
) (
  input  wire logic        i_clk,
  input  wire logic        i_rd_n,
  input  wire logic        i_wr_n,
  input  wire logic [15:0] i_ad_out,
  input  wire logic        i_ad_oe_n,
  input  wire logic        i_ready_pol,
  input  wire logic [3:0]  i_ready_delay,
  output logic [15:0]      o_ad_in,
  output logic             o_ready,
  output logic [15:0]      o_last_wdata
);
  logic [3:0]  cnt_ff   = 4'h0;
  logic [15:0] float_ff = 16'h5555;
  logic        active;
  // a released bus toggles so a stale value never passes for read data
  assign active  = (i_rd_n === 1'b0) || (i_wr_n === 1'b0);
  assign o_ad_in = (i_rd_n === 1'b0) ? RD_WORD : float_ff;
  assign o_ready = (active && cnt_ff >= i_ready_delay) ? i_ready_pol : ~i_ready_pol;
  always_ff @(posedge i_clk) begin
    cnt_ff   <= active ? cnt_ff + ((cnt_ff == 4'hf) ? 4'h0 : 4'h1) : 4'h0;
    float_ff <= ~float_ff;
    if (i_wr_n === 1'b0 && i_ad_oe_n === 1'b0) begin
      o_last_wdata <= i_ad_out;
    end
  end
endmodule

// [dv/tb_ebu_window_ctrl.sv]
// self-checking bench for the external bus unit window controller
`timescale 1ns/100ps
`include "ebu_params.svh"
module tb_ebu_window_ctrl;
  localparam logic [15:0] RD_WORD = 16'hc3a5;
  logic i_clk = 1'b0, i_rst = 1'b1, i_select_timing_choice = 1'b0, i_arbitration_on = 1'b0;
  logic i_grant_pin_direction = 1'b0, i_req = 1'b0, i_req_write = 1'b0, i_ready;
  logic i_bus_grab_req_n = 1'b1, i_grant_acknowledge_n = 1'b1, rdy_pol = 1'b0, rw_seen;
  logic [1:0] i_space_limit = 2'h0;
  logic [3:0] rdy_dly = 4'h0;
  logic [23:0] i_req_addr = 24'h0;
  logic [15:0] i_req_wdata = 16'h5a3c, i_shared_ad_lines, last_wdata, stb_ad, stb_dmx;
  logic o_req_done, o_shared_ad_oe_n, o_addr_strobe, o_rd_n, o_wr_n, o_bus_want_out_n;
  logic o_grant_acknowledge_n, o_grant_ack_oe_n, o_bus_floated;
  logic [15:0] o_req_rdata, o_shared_ad_lines, o_demux_addr_lines;
  logic [7:0] o_segment_addr, stb_seg;
  logic [4:0] o_window_select_n, sel;
  ebu_pkg::bus_settings_t st [5];
  ebu_pkg::window_range_t rg [4];
  logic [23:0] ta [5] = '{24'h300050, 24'h100010, 24'h101020, 24'h200030, 24'h202040};
  logic [7:0] segm [4] = '{`EBU_SEG_16M, `EBU_SEG_1M, `EBU_SEG_256K, `EBU_SEG_64K};
  int n_mismatch = 0, comparisons = 0, cyc = 0, len, len_fast, skew, t_stb, t_sel;

  always #12.5 i_clk = ~i_clk;

  ebu_window_ctrl uut (.i_clk, .i_rst, .i_default_bus_settings(st[0]),
    .i_window_one_settings(st[1]), .i_window_two_settings(st[2]),
    .i_window_three_settings(st[3]), .i_window_four_settings(st[4]),
    .i_range_one(rg[0]), .i_range_two(rg[1]), .i_range_three(rg[2]), .i_range_four(rg[3]),
    .i_space_limit, .i_select_timing_choice, .i_arbitration_on, .i_grant_pin_direction,
    .i_req, .i_req_write, .i_req_addr, .i_req_wdata, .i_ready, .i_shared_ad_lines,
    .i_bus_grab_req_n, .i_grant_acknowledge_n, .o_req_done, .o_req_rdata,
    .o_shared_ad_lines, .o_shared_ad_oe_n, .o_demux_addr_lines, .o_segment_addr,
    .o_addr_strobe, .o_rd_n, .o_wr_n, .o_window_select_n, .o_bus_want_out_n,
    .o_grant_acknowledge_n, .o_grant_ack_oe_n, .o_bus_floated);

  ebu_mem_model #(.RD_WORD(RD_WORD)) mem (.i_clk, .i_rd_n(o_rd_n), .i_wr_n(o_wr_n),
    .i_ad_out(o_shared_ad_lines), .i_ad_oe_n(o_shared_ad_oe_n), .i_ready_pol(rdy_pol),
    .i_ready_delay(rdy_dly), .o_ad_in(i_shared_ad_lines), .o_ready(i_ready),
    .o_last_wdata(last_wdata));

  // ****************************************
  // bench tasks
  // ****************************************
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  function automatic ebu_pkg::bus_settings_t bs(input logic [2:0] m, input logic re,
                                                input logic rp);
    bs = '{1'b1, m, 4'h0, 4'h0, 1'b0, 1'b0, re, rp};
  endfunction

  // request held until done, bus activity recorded cycle by cycle
  task automatic acc(input logic w, input logic [23:0] a);
    @(negedge i_clk);
    i_req = 1'b1;
    i_req_write = w;
    i_req_addr = a;
    len = 0;
    sel = 5'h1f;
    t_stb = -1;
    t_sel = -1;
    rw_seen = 1'b0;
    while (o_req_done !== 1'b1 && len < 60) begin
      @(posedge i_clk);
      #1;
      len++;
      sel &= o_window_select_n;
      if (t_sel < 0 && o_window_select_n !== 5'h1f) t_sel = len;
      if (t_stb < 0 && o_addr_strobe === 1'b1) begin
        t_stb = len;
        stb_ad = o_shared_ad_lines;
        stb_dmx = o_demux_addr_lines;
        stb_seg = o_segment_addr;
      end
      if (o_rd_n === 1'b0 || o_wr_n === 1'b0) rw_seen = 1'b1;
    end
    if (len >= 60) n_mismatch++;
    skew = t_sel - t_stb;
    @(negedge i_clk);
    i_req = 1'b0;
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // the whole run needs a few hundred cycles at most
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      test_done;
    end
  end

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    st[0] = bs(`EBU_MODE_M16, 1'b0, 1'b0);
    st[1] = bs(`EBU_MODE_D16, 1'b0, 1'b0);
    st[2] = bs(`EBU_MODE_M8, 1'b0, 1'b0);
    st[3] = bs(`EBU_MODE_M16, 1'b1, 1'b0);
    st[4] = bs(`EBU_MODE_M16, 1'b0, 1'b0);
    rg = '{'{12'h100, 4'h2}, '{12'h101, 4'h0}, '{12'h200, 4'h2}, '{12'h202, 4'h0}};
    repeat (10) @(negedge i_clk);
    i_rst = 1'b0;
    check("idle selects", o_window_select_n, 5'h1f);
    check("grant pin out", o_grant_ack_oe_n, 1'b0);
    for (int k = 0; k < 5; k++) begin
      acc(1'b0, ta[k]);
      check("window select", sel, 5'(~(5'h01 << k)));
      check("read data", o_req_rdata, (k == 2) ? {8'h00, RD_WORD[7:0]} : RD_WORD);
      check("late select", skew, 1);
      if (k == 1) check("demux address", stb_dmx, 16'h0010);
      if (k == 2) check("mux address", stb_ad, 16'h1020);
    end
    acc(1'b1, 24'h300070);
    check("write data", last_wdata, i_req_wdata);
    st[1] = bs(`EBU_MODE_D8, 1'b0, 1'b0);
    acc(1'b1, 24'h100010);
    check("byte write", last_wdata, {8'h00, i_req_wdata[7:0]});
    acc(1'b0, 24'h100010);
    check("byte read", o_req_rdata, {8'h00, RD_WORD[7:0]});
    st[1] = bs(`EBU_MODE_D16, 1'b0, 1'b0);
    for (int k = 0; k < 4; k++) begin
      i_space_limit = k[1:0];
      acc(1'b0, 24'h3a5060);
      check("segment lines", stb_seg, 8'h3a & segm[k]);
    end
    i_space_limit = 2'h0;
    i_select_timing_choice = 1'b1;
    acc(1'b0, 24'h300050);
    check("early select", skew, 0);
    i_select_timing_choice = 1'b0;
    st[0] = bs(`EBU_MODE_OFF, 1'b0, 1'b0);
    acc(1'b0, 24'h300000);
    check("no strobe", rw_seen, 1'b0);
    check("no select", sel, 5'h1f);
    st[0] = '{1'b1, `EBU_MODE_M16, 4'h2, 4'h1, 1'b1, 1'b1, 1'b0, 1'b0};
    acc(1'b0, 24'h300000);
    check("timed cycle", len, 8);
    check("timed select", skew, 1);
    st[0] = bs(`EBU_MODE_M16, 1'b0, 1'b0);
    acc(1'b0, 24'h300000);
    check("tristate gap", len, 5);
    st[0] = bs(`EBU_MODE_M16, 1'b0, 1'b0);
    acc(1'b0, 24'h200030);
    len_fast = len;
    rdy_dly = 4'h4;
    acc(1'b0, 24'h200030);
    check("ready low wait", len, len_fast + 3);
    rdy_pol = 1'b1;
    st[3] = bs(`EBU_MODE_M16, 1'b1, 1'b1);
    rdy_dly = 4'h2;
    acc(1'b0, 24'h200030);
    check("ready high wait", len, len_fast + 1);
    rdy_dly = 4'h0;
    i_bus_grab_req_n = 1'b0;
    repeat (6) @(negedge i_clk);
    check("grant while off", o_grant_acknowledge_n, 1'b1);
    i_arbitration_on = 1'b1;
    len = 0;
    while (o_grant_acknowledge_n !== 1'b0 && len < 20) begin
      @(negedge i_clk);
      len++;
    end
    check("grant given", o_grant_acknowledge_n, 1'b0);
    check("bus floated", o_bus_floated, 1'b1);
    check("ad lines off", o_shared_ad_oe_n, 1'b1);
    i_bus_grab_req_n = 1'b1;
    repeat (4) @(negedge i_clk);
    check("grant withdrawn", o_grant_acknowledge_n, 1'b1);
    i_grant_pin_direction = 1'b1;
    repeat (4) @(negedge i_clk);
    check("grant pin in", o_grant_ack_oe_n, 1'b1);
    i_req = 1'b1;
    i_req_addr = 24'h300050;
    repeat (3) @(negedge i_clk);
    check("bus wanted", o_bus_want_out_n, 1'b0);
    check("slave waits", o_addr_strobe, 1'b0);
    i_req = 1'b0;
    i_grant_acknowledge_n = 1'b0;
    acc(1'b0, 24'h300050);
    check("slave cycle", len, 4);
    test_done;
  end
endmodule
